// [lhpm_top.sv]
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module lhpm_top (
   input  wire logic                  i_mclk,
   input  wire logic                  i_reset,
   // Register port.
   input  wire logic [7:0]            i_addr,
   input  wire logic [31:0]           i_wr_data,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [31:0]           o_rd_data,
   // Internal display pipeline, same clock.
   input  wire lhpm_pkg::lhpm_timing_t i_timing,
   input  wire logic [17:0]           i_pixel,
   input  wire logic [3:0]            i_panel_strobe,
   input  wire logic [9:0]            i_type3_ctrl,
   // Internal USB core, same clock.
   input  wire logic                  i_usb_pullup_ctrl,
   input  wire logic [1:0]            i_usb_line_out,
   input  wire logic [1:0]            i_usb_line_drive,
   output logic                       o_usb_cable_detect,
   output logic      [1:0]            o_usb_line_in,
   // Panel pins.
   output lhpm_pkg::lhpm_panel_t      o_panel,
   output logic      [10:0]           o_general_output_pin,
   // General purpose two-way pins.
   input  wire logic [7:0]            i_gpio_in,
   output logic      [7:0]            o_gpio_out,
   output logic      [7:0]            o_gpio_oe_n,
   // Host bus pins and straps.
   input  wire logic [6:0]            i_config_straps,
   input  wire logic                  i_host_ab0,
   input  wire logic                  i_host_we1_n,
   output lhpm_pkg::lhpm_lanes_t      o_lanes,
   output lhpm_pkg::lhpm_cfg_t        o_cfg
);

   // ------------------------------------------------------------
   // State.
   // ------------------------------------------------------------
   typedef struct packed {
      logic [5:0]            panel_cfg;
      lhpm_pkg::lhpm_mode_t  act_mode;
      logic                  act_en;
      logic                  act_usb;
      logic [7:0]            gpio_dout;
      logic [7:0]            gpio_dir;
      logic [10:0]           general_output_pin;
      logic [6:0]            straps;
      logic                  cfg_taken;
      logic                  frame_prev;
      lhpm_pkg::lhpm_panel_t panel;
      logic [10:0]           gpo_out;
      logic [7:0]            gpio_out;
      logic [7:0]            gpio_oe_n;
      logic                  usb_detect;
      logic [1:0]            usb_line_in;
      lhpm_pkg::lhpm_lanes_t lanes;
      lhpm_pkg::lhpm_cfg_t   cfg;
      logic [31:0]           rd_data;
   } lhpm_top_state_t;

   lhpm_top_state_t st;
   lhpm_top_state_t next_st;

   // ------------------------------------------------------------
   // Pin synchronisers and data map.
   // ------------------------------------------------------------
   logic [16:0] pin_sync;
   logic [7:0]  gpio_sync;
   logic [6:0]  strap_sync;
   logic        ab0_sync;
   logic        we1_n_sync;
   logic [17:0] mapped;

   lhpm_sync2 #(
      .W (17)
   ) u_sync (
      .i_mclk  (i_mclk),
      .i_async ({i_gpio_in, i_config_straps, i_host_ab0, i_host_we1_n}),
      .o_sync  (pin_sync)
   );

   assign gpio_sync  = pin_sync[16:9];
   assign strap_sync = pin_sync[8:2];
   assign ab0_sync   = pin_sync[1];
   assign we1_n_sync = pin_sync[0];

   // The map follows the active mode only, so data pins move with the strobes.
   lhpm_data_map u_map (
      .i_mode  (st.act_mode),
      .i_pixel (i_pixel),
      .o_pins  (mapped)
   );

   // ------------------------------------------------------------
   // Next-state logic.
   // ------------------------------------------------------------
   logic                 frame_rise;
   lhpm_pkg::lhpm_mode_t req_mode;
   lhpm_pkg::lhpm_mode_t m;
   logic                 strobe_mode;
   logic                 ign_a0;

   assign frame_rise = i_timing.frame & ~st.frame_prev;
   assign req_mode   = lhpm_pkg::lhpm_mode_t'(st.panel_cfg[lhpm_pkg::PANEL_MODE_LSB +: 4]);
   assign m          = st.act_mode;
   assign strobe_mode = (m == lhpm_pkg::MODE_REFL) || (m == lhpm_pkg::MODE_ALT)
                     || (m == lhpm_pkg::MODE_TFT2) || (m == lhpm_pkg::MODE_TFT3);
   assign ign_a0     = (st.cfg.bus == lhpm_pkg::BUS_GEN_A) || (st.cfg.bus == lhpm_pkg::BUS_SH)
                     || (st.cfg.bus == lhpm_pkg::BUS_NOWAIT)
                     || (st.cfg.bus == lhpm_pkg::BUS_M68K_LIT);

   always_comb
   begin
      next_st            = st;
      next_st.frame_prev = i_timing.frame;

      // Register writes.
      if (i_wr)
      begin
         case (i_addr)
            lhpm_pkg::OFS_PANEL:
            begin
               next_st.panel_cfg = i_wr_data[5:0];
            end
            lhpm_pkg::OFS_GPIO:
            begin
               next_st.gpio_dout = i_wr_data[7:0];
               next_st.gpio_dir  = i_wr_data[lhpm_pkg::GPIO_DIR_LSB +: 8];
            end
            lhpm_pkg::OFS_GPO:
            begin
               next_st.general_output_pin = i_wr_data[10:0];
            end
            default:
            begin
               next_st.general_output_pin = st.general_output_pin;
            end
         endcase
      end

      // Read data stand for one cycle only; unmapped words read zero.
      next_st.rd_data = 32'h0000_0000;
      if (i_rd)
      begin
         case (i_addr)
            lhpm_pkg::OFS_PANEL:
            begin
               next_st.rd_data[5:0] = st.panel_cfg;
            end
            lhpm_pkg::OFS_GPIO:
            begin
               next_st.rd_data[7:0]                       = st.gpio_dout;
               next_st.rd_data[lhpm_pkg::GPIO_DIR_LSB +: 8] = st.gpio_dir;
            end
            lhpm_pkg::OFS_GPO:
            begin
               next_st.rd_data[10:0] = st.general_output_pin;
            end
            lhpm_pkg::OFS_STATUS:
            begin
               next_st.rd_data[6:0]                         = st.straps;
               next_st.rd_data[lhpm_pkg::STAT_MODE_LSB +: 4] = st.act_mode;
               next_st.rd_data[lhpm_pkg::STAT_GPIN_LSB +: 8] = gpio_sync;
            end
            default:
            begin
               next_st.rd_data = 32'h0000_0000;
            end
         endcase
      end

      // Straps are caught once, on the first cycle after reset release.
      // The synchroniser is not reset, so it already holds the strap level.
      if (!st.cfg_taken)
      begin
         next_st.cfg_taken      = 1'b1;
         next_st.straps         = strap_sync;
         next_st.cfg.bus        = lhpm_pkg::lhpm_bus_t'(strap_sync[lhpm_pkg::STRAP_BUS_LSB +: 3]);
         next_st.cfg.big_endian = strap_sync[lhpm_pkg::STRAP_ENDIAN];
         next_st.cfg.wait_high  = strap_sync[lhpm_pkg::STRAP_WAIT_POL];
         next_st.cfg.clk_div2   = strap_sync[lhpm_pkg::STRAP_CLK_DIV];
      end

      // A new mode takes effect at a frame start, or at once while the
      // panel is off; switching mid-frame would tear a line on the glass.
      if (!st.act_en || frame_rise)
      begin
         next_st.act_mode = req_mode;
         next_st.act_en   = st.panel_cfg[lhpm_pkg::PANEL_EN_BIT];
      end
      next_st.act_usb = st.panel_cfg[lhpm_pkg::PANEL_USB_BIT];

      // Panel timing pins; TFT panels reuse the same three pins.
      next_st.panel.frame_pulse       = st.act_en & i_timing.frame;
      next_st.panel.line_pulse        = st.act_en & i_timing.line;
      next_st.panel.pixel_shift_clock = st.act_en & i_timing.shift;
      // Data is registered in the same stage as the shift clock, so the
      // component on each pin is the one seen at its first shift edge.
      next_st.panel.panel_data_pins = st.act_en ? mapped : 18'h0_0000;

      // Ready pin carries modulation, second shift, ready or invert; it is held low in MODE_REFL and MODE_ALT.
      case (m)
         lhpm_pkg::MODE_MONO4, lhpm_pkg::MODE_MONO8, lhpm_pkg::MODE_COL4:
         begin
            next_st.panel.data_ready_out = i_timing.ac_mod;
         end
         lhpm_pkg::MODE_COL8F1:
         begin
            next_st.panel.data_ready_out = i_timing.shift2;
         end
         lhpm_pkg::MODE_COL8F2, lhpm_pkg::MODE_COL16:
         begin
            next_st.panel.data_ready_out = i_timing.ac_mod;
         end
         lhpm_pkg::MODE_REFL, lhpm_pkg::MODE_ALT:
         begin
            next_st.panel.data_ready_out = 1'b0;
         end
         lhpm_pkg::MODE_TFT2, lhpm_pkg::MODE_TFT3:
         begin
            next_st.panel.data_ready_out = i_timing.invert;
         end
         default:
         begin
            next_st.panel.data_ready_out = i_timing.ready;
         end
      endcase
      if (!st.act_en)
      begin
         next_st.panel.data_ready_out = 1'b0;
      end

      // General outputs; type 3 TFT takes over bits 1 to 10.
      next_st.gpo_out = st.general_output_pin;
      if (st.act_en && m == lhpm_pkg::MODE_TFT3)
      begin
         next_st.gpo_out[10:1] = i_type3_ctrl;
      end

      // GPIO pins: software direction decides the driver except for USB; the borrowed
      // pins only change their source, so a missing direction write
      // leaves them undriven rather than fighting the panel.
      for (int i = 0; i < 8; i++)
      begin
         next_st.gpio_out[i]  = st.gpio_dout[i];
         next_st.gpio_oe_n[i] = ~st.gpio_dir[i];
      end
      if (st.act_en && strobe_mode)
      begin
         next_st.gpio_out[3:0] = i_panel_strobe;
      end

      // USB borrows pins 4 to 7.
      next_st.usb_detect  = st.act_usb & gpio_sync[5];
      next_st.usb_line_in = st.act_usb ? gpio_sync[7:6] : 2'b00;
      if (st.act_usb)
      begin
         next_st.gpio_out[4]    = i_usb_pullup_ctrl;
         next_st.gpio_oe_n[4]   = 1'b0;
         next_st.gpio_out[5]    = 1'b0;
         next_st.gpio_oe_n[5]   = 1'b1;
         next_st.gpio_out[7:6]  = i_usb_line_out;
         next_st.gpio_oe_n[7:6] = ~i_usb_line_drive;
      end

      // Host lane reinterpretation; strobes idle high.
      next_st.lanes.addr0               = ign_a0 ? 1'b0 : ab0_sync;
      next_st.lanes.byte_high_enable_n  = 1'b1;
      next_st.lanes.upper_data_strobe_n = 1'b1;
      next_st.lanes.lower_data_strobe_n = 1'b1;
      next_st.lanes.data_strobe_n       = 1'b1;
      case (st.cfg.bus)
         lhpm_pkg::BUS_GEN_B:
         begin
            next_st.lanes.byte_high_enable_n = we1_n_sync;
         end
         lhpm_pkg::BUS_M68K_A:
         begin
            next_st.lanes.upper_data_strobe_n = we1_n_sync;
            next_st.lanes.lower_data_strobe_n = ab0_sync;
            next_st.lanes.addr0               = 1'b0;
         end
         lhpm_pkg::BUS_M68K_B:
         begin
            // Sixteen data pins sit on the host's upper lanes when 32 wide.
            next_st.lanes.data_strobe_n = we1_n_sync;
         end
         default:
         begin
            next_st.lanes.data_strobe_n = 1'b1;
         end
      endcase

      // Synchronous reset; straps are re-taken after release.
      if (i_reset)
      begin
         next_st            = '0;
         next_st.panel_cfg  = lhpm_pkg::PANEL_RESET;
         next_st.gpio_dout  = lhpm_pkg::GPIO_RESET;
         next_st.gpio_dir   = lhpm_pkg::GPIO_RESET;
         next_st.general_output_pin        = lhpm_pkg::GPO_RESET;
         next_st.gpo_out    = lhpm_pkg::GPO_RESET;
         next_st.gpio_oe_n  = 8'hFF;
         next_st.lanes      = 5'h0F;
      end
   end

   // ------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      st <= next_st;
   end

   // All outputs come straight from the state register.
   assign o_rd_data            = st.rd_data;
   assign o_panel              = st.panel;
   assign o_general_output_pin = st.gpo_out;
   assign o_gpio_out           = st.gpio_out;
   assign o_gpio_oe_n          = st.gpio_oe_n;
   assign o_usb_cable_detect   = st.usb_detect;
   assign o_usb_line_in        = st.usb_line_in;
   assign o_lanes              = st.lanes;
   assign o_cfg                = st.cfg;

endmodule // lhpm_top

// [lhpm_pkg.sv]
package lhpm_pkg;

   // ------------------------------------------------------------
   // Register map.
   // ------------------------------------------------------------
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] OFS_PANEL      = 8'h00;
   localparam logic [7:0] OFS_GPIO       = 8'h04;
   localparam logic [7:0] OFS_GPO        = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0C;
   localparam int         PANEL_MODE_LSB = 0;
   localparam int         PANEL_USB_BIT  = 4;
   localparam int         PANEL_EN_BIT   = 5;
   localparam int         GPIO_DIR_LSB   = 16;
   localparam int         STAT_MODE_LSB  = 8;
   localparam int         STAT_GPIN_LSB  = 12;
   localparam logic [5:0] PANEL_RESET    = 6'h00;
   localparam logic [7:0] GPIO_RESET     = 8'h00;
   localparam logic [10:0] GPO_RESET     = 11'h000;

   // ------------------------------------------------------------
   // Strap fields.
   // ------------------------------------------------------------
   localparam int STRAP_BUS_LSB  = 0;
   localparam int STRAP_ENDIAN   = 4;
   localparam int STRAP_WAIT_POL = 5;
   localparam int STRAP_CLK_DIV  = 6;

   typedef enum logic [3:0] {
      MODE_MONO4   = 4'h0,
      MODE_MONO8   = 4'h1,
      MODE_COL4    = 4'h2,
      MODE_COL8F1  = 4'h3,
      MODE_COL8F2  = 4'h4,
      MODE_COL16   = 4'h5,
      MODE_TFT9    = 4'h6,
      MODE_TFT12   = 4'h7,
      MODE_TFT18   = 4'h8,
      MODE_REFL    = 4'h9,
      MODE_ALT     = 4'hA,
      MODE_TFT2    = 4'hB,
      MODE_TFT3    = 4'hC,
      MODE_TFT4_18 = 4'hD,
      MODE_TFT4_12 = 4'hE,
      MODE_TFT4_9  = 4'hF
   } lhpm_mode_t;

   typedef enum logic [2:0] {
      BUS_SH       = 3'h0,
      BUS_M68K_A   = 3'h1,
      BUS_M68K_B   = 3'h2,
      BUS_GEN_A    = 3'h3,
      BUS_GEN_B    = 3'h4,
      BUS_NOWAIT   = 3'h5,
      BUS_M68K_LIT = 3'h6,
      BUS_RSVD     = 3'h7
   } lhpm_bus_t;

   typedef struct packed {
      logic frame;
      logic line;
      logic shift;
      logic shift2;
      logic ac_mod;
      logic ready;
      logic invert;
   } lhpm_timing_t;

   typedef struct packed {
      logic        frame_pulse;
      logic        line_pulse;
      logic        pixel_shift_clock;
      logic        data_ready_out;
      logic [17:0] panel_data_pins;
   } lhpm_panel_t;

   typedef struct packed {
      logic addr0;
      logic byte_high_enable_n;
      logic upper_data_strobe_n;
      logic lower_data_strobe_n;
      logic data_strobe_n;
   } lhpm_lanes_t;

   typedef struct packed {
      lhpm_bus_t bus;
      logic      big_endian;
      logic      wait_high;
      logic      clk_div2;
   } lhpm_cfg_t;

endpackage

// [lhpm_sync2.sv]
`timescale 1ns/1ps
module lhpm_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   // Two stages; the first is read only by the second.
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lhpm_sync_state_t;

   lhpm_sync_state_t st;
   lhpm_sync_state_t next_st;

   // No reset: a pin level is not control state.
   always_comb
   begin
      next_st    = st;
      next_st.s1 = i_async;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge i_mclk)
   begin
      st <= next_st;
   end

   assign o_sync = st.s2;

endmodule // lhpm_sync2

// [lhpm_data_map.sv]
`timescale 1ns/1ps
module lhpm_data_map (
   input  wire lhpm_pkg::lhpm_mode_t i_mode,
   input  wire logic [17:0]          i_pixel,
   output logic      [17:0]          o_pins
);

   // Pixel word: red 17:12, green 11:6, blue 5:0 for TFT; D15..D0 for passive.
   logic [2:0][5:0] col;

   assign col = {i_pixel[5:0], i_pixel[11:6], i_pixel[17:12]};

   // Pin mapping; every pin not assigned below stays low.
   always_comb
   begin
      o_pins = 18'h0_0000;
      case (i_mode)
         lhpm_pkg::MODE_MONO4, lhpm_pkg::MODE_COL4:
         begin
            o_pins[7:4] = i_pixel[3:0];
         end
         lhpm_pkg::MODE_MONO8, lhpm_pkg::MODE_COL8F1, lhpm_pkg::MODE_COL8F2:
         begin
            o_pins[7:0] = i_pixel[7:0];
         end
         lhpm_pkg::MODE_COL16:
         begin
            o_pins[3:0]   = i_pixel[3:0];
            o_pins[7:4]   = i_pixel[11:8];
            o_pins[11:8]  = i_pixel[7:4];
            o_pins[15:12] = i_pixel[15:12];
         end
         lhpm_pkg::MODE_TFT9, lhpm_pkg::MODE_TFT4_9:
         begin
            for (int c = 0; c < 3; c++)
            begin
               for (int k = 0; k < 3; k++)
               begin
                  o_pins[c*3+k] = col[c][5-k];
               end
            end
         end
         lhpm_pkg::MODE_TFT12, lhpm_pkg::MODE_TFT4_12:
         begin
            for (int c = 0; c < 3; c++)
            begin
               for (int k = 0; k < 3; k++)
               begin
                  o_pins[c*3+k] = col[c][5-k];
               end
               o_pins[9+c*3] = col[c][2];
            end
         end
         default:
         begin
            // All 18-bit TFT variants share one map.
            for (int c = 0; c < 3; c++)
            begin
               for (int k = 0; k < 3; k++)
               begin
                  o_pins[c*3+k]   = col[c][5-k];
                  o_pins[9+c*3+k] = col[c][2-k];
               end
            end
         end
      endcase
   end

endmodule // lhpm_data_map

// [lhpm_monitor.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the pin multiplexer.
// ------------------------------------------------------------
module lhpm_monitor (
   input wire logic                  i_mclk,
   input wire logic                  i_reset,
   input wire logic                  i_rd,
   input wire logic [7:0]            i_addr,
   input wire logic [31:0]           o_rd_data,
   input wire logic                  i_host_we1_n,
   input wire logic [7:0]            i_gpio_in,
   input wire logic                  o_usb_cable_detect,
   input wire logic [7:0]            o_gpio_oe_n,
   input wire lhpm_pkg::lhpm_lanes_t o_lanes,
   input wire lhpm_pkg::lhpm_cfg_t   o_cfg
);
   logic [3:0] run_cnt;

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   // Cycles since reset release; the byte enable and strobe lane checks wait until the synchronisers hold real pin history.
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
         run_cnt <= 4'h0;
      else if (run_cnt != 4'hF)
         run_cnt <= run_cnt + 4'h1;
   end

   property p_oe_reset; $fell(i_reset) |-> o_gpio_oe_n == 8'hFF; endproperty
   a_oe_reset: assert property (p_oe_reset) else $error("pins driven after reset");
   property p_status;
      i_rd && i_addr == lhpm_pkg::OFS_STATUS && run_cnt > 4'h3 |=> o_rd_data[2:0] == o_cfg.bus;
   endproperty
   a_status: assert property (p_status) else $error("status bus field wrong");
   property p_cfg; run_cnt > 4'h1 |-> $stable(o_cfg); endproperty
   a_cfg: assert property (p_cfg) else $error("straps changed after reset");
   property p_addr0;
      o_cfg.bus inside {lhpm_pkg::BUS_SH, lhpm_pkg::BUS_GEN_A, lhpm_pkg::BUS_NOWAIT, lhpm_pkg::BUS_M68K_LIT,
                        lhpm_pkg::BUS_M68K_A} |-> !o_lanes.addr0;
   endproperty
   a_addr0: assert property (p_addr0) else $error("address bit zero passed");
   property p_bhe;
      run_cnt > 4'h5 && o_cfg.bus == lhpm_pkg::BUS_GEN_B |-> o_lanes.byte_high_enable_n == $past(i_host_we1_n, 3);
   endproperty
   a_bhe: assert property (p_bhe) else $error("byte high enable wrong");
   property p_uds;
      run_cnt > 4'h5 && o_cfg.bus == lhpm_pkg::BUS_M68K_A |-> o_lanes.upper_data_strobe_n == $past(i_host_we1_n, 3);
   endproperty
   a_uds: assert property (p_uds) else $error("upper strobe wrong");
   property p_ds;
      run_cnt > 4'h5 && o_cfg.bus == lhpm_pkg::BUS_M68K_B |-> o_lanes.data_strobe_n == $past(i_host_we1_n, 3);
   endproperty
   a_ds: assert property (p_ds) else $error("data strobe wrong");
   property p_detect; $rose(o_usb_cable_detect) |-> $past(i_gpio_in[5], 3); endproperty
   a_detect: assert property (p_detect) else $error("cable detect without cause");
endmodule // lhpm_monitor

// [lhpm_board.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board model: pin wires and host address bit zero pin.
// ------------------------------------------------------------
module lhpm_board (
   input  wire logic [7:0] i_gpio_out,
   input  wire logic [7:0] i_gpio_oe_n,
   input  wire logic [7:0] i_ext_level,
   input  wire logic       i_ab0_fault,
   output logic      [7:0] o_gpio_wire,
   output logic            o_host_ab0
);
   // A pin shows the device level while its enable is low, else what the board drives.
   assign o_gpio_wire = (i_gpio_out & ~i_gpio_oe_n) | (i_ext_level & i_gpio_oe_n);
   // The host ties address bit zero low unless a scenario breaks that on purpose.
   assign o_host_ab0 = i_ab0_fault;
   // A wide host wires our sixteen data pins to its upper lanes; the block sees no difference.
   // The host ties its read/write pin high where the bus has no use for it; the block has no such pin.
endmodule // lhpm_board

// [lhpm_tb.sv]
`timescale 1ns/1ps
module tb;
   logic clk, rst, wr, rd, pup, ab0f, ab0, we1, det;
   logic [7:0] addr, gin, gout, goen, ext;
   logic [31:0] wdata, rdata;
   lhpm_pkg::lhpm_timing_t tim;
   logic [17:0] pix;
   logic [3:0] strb;
   logic [9:0] t3;
   logic [1:0] lo, ld, li;
   logic [10:0] general_output_pin;
   logic [6:0] straps;
   lhpm_pkg::lhpm_panel_t pan;
   lhpm_pkg::lhpm_lanes_t lanes;
   lhpm_pkg::lhpm_cfg_t cfg;
   int errors, samples_checked;

   lhpm_top dut (.i_mclk(clk), .i_reset(rst), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd),
      .o_rd_data(rdata), .i_timing(tim), .i_pixel(pix), .i_panel_strobe(strb), .i_type3_ctrl(t3),
      .i_usb_pullup_ctrl(pup), .i_usb_line_out(lo), .i_usb_line_drive(ld), .o_usb_cable_detect(det),
      .o_usb_line_in(li), .o_panel(pan), .o_general_output_pin(general_output_pin), .i_gpio_in(gin), .o_gpio_out(gout),
      .o_gpio_oe_n(goen), .i_config_straps(straps), .i_host_ab0(ab0), .i_host_we1_n(we1), .o_lanes(lanes),
      .o_cfg(cfg));
   lhpm_board board (.i_gpio_out(gout), .i_gpio_oe_n(goen), .i_ext_level(ext), .i_ab0_fault(ab0f),
      .o_gpio_wire(gin), .o_host_ab0(ab0));

   // Free running clock.
   always #2 clk = ~clk;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk) {rd, addr} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Straps are set with reset asserted so they are stable before release.
   task automatic lane_case(input logic [2:0] b);
      logic [31:0] d;
      @(posedge clk) {rst, straps} <= {1'b1, 4'h5, b};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk) {ab0f, we1} <= 2'b10;
      #1 chk("oe_n", 32'hFF, goen);
      repeat (4) @(posedge clk);
      rd_reg(lhpm_pkg::OFS_STATUS, d);
      chk("straps", {4'h5, b}, d[6:0]);
      straps <= 7'h2F;
      repeat (6) @(posedge clk);
      #1 chk("cfg", {b, 3'b010}, cfg);
      chk("lanes", {b == 3'h2 || b == 3'h4, b != 3'h4, b != 3'h1, 1'b1, b != 3'h2}, lanes);
      @(posedge clk) {ab0f, we1} <= 2'b01;
   endtask

   function automatic logic [17:0] exp_pins(input logic [3:0] m, input logic [17:0] p);
      logic [17:0] e;
      e = 18'h0_0000;
      case (m)
         4'h0, 4'h2: e[7:4] = p[3:0];
         4'h1, 4'h3, 4'h4: e[7:0] = p[7:0];
         4'h5: e[15:0] = {p[15:12], p[7:4], p[11:8], p[3:0]};
         default:
            for (int i = 0; i < 3; i++)
            begin
               {e[i], e[3 + i], e[6 + i]} = {p[17 - i], p[11 - i], p[5 - i]};
               if (m == 4'h7 || m == 4'hE)
                  e[9 + 3 * i] = p[14 - 6 * i];
               else if (m != 4'h6 && m != 4'hF)
                  {e[9 + i], e[12 + i], e[15 + i]} = {p[14 - i], p[8 - i], p[2 - i]};
            end
      endcase
      return e;
   endfunction

   // The frame input must sit low for a cycle before it rises, or no frame start is seen.
   task automatic frame_edge;
      @(posedge clk) tim <= 7'h00;
      @(posedge clk) tim <= 7'h40;
   endtask

   // Each mode is applied through a frame start, then the panel, general output and low four GPIO pins are compared.
   task automatic panel_case(input logic [3:0] m, input lhpm_pkg::lhpm_timing_t tp);
      logic r;
      case (m)
         4'h3: r = tp.shift2;
         4'h9, 4'hA: r = 1'b0;
         4'hB, 4'hC: r = tp.invert;
         4'h0, 4'h1, 4'h2, 4'h4, 4'h5: r = tp.ac_mod;
         default: r = tp.ready;
      endcase
      wr_reg(lhpm_pkg::OFS_PANEL, {26'h000_0000, 2'b10, m});
      frame_edge();
      @(posedge clk) tim <= tp;
      repeat (4) @(posedge clk);
      #1 chk("data", exp_pins(m, pix), pan.panel_data_pins);
      chk("ready", r, pan.data_ready_out);
      chk("timing", tp[6:4], {pan.frame_pulse, pan.line_pulse, pan.pixel_shift_clock});
      chk("gpio", {4'h0, ((m > 4'h8 && m < 4'hD) ? strb : 4'hA)}, {goen[3:0], gout[3:0]});
      chk("gpo", {(m == 4'hC) ? t3 : 10'h2AA, 1'b1}, general_output_pin);
   endtask

   task automatic usb_case;
      wr_reg(lhpm_pkg::OFS_PANEL, 32'h0000_0010);
      frame_edge();
      @(posedge clk) {pup, ld, lo} <= 5'b10001;
      repeat (6) @(posedge clk);
      #1 chk("usb_oe", 3'b110, goen[6:4]);
      chk("usb", {2'b01, 2'b10, 1'b1, 1'b1}, {gout[7:6], li, det, gout[4]});
      chk("off_pins", 32'h0, pan.panel_data_pins);
   endtask

   initial
   begin
      {clk, rst, wr, rd, pup, ab0f, we1, addr, wdata} = {3'b010, 3'b001, 1'b1, 8'h00, 32'h0000_0000};
      {tim, pix, strb, t3, lo, ld, ext, straps} = {7'h00, 18'h2_D3A5, 4'h6, 10'h2CC, 4'h0, 8'hA0, 7'h00};
      for (int k = 0; k < 7; k++) lane_case(3'(k));
      wr_reg(lhpm_pkg::OFS_GPIO, 32'h00FF_000A);
      wr_reg(lhpm_pkg::OFS_GPO, 32'h0000_0555);
      for (int m = 0; m < 16; m++)
      begin
         panel_case(m[3:0], 7'h25);
         panel_case(m[3:0], 7'h5A);
      end
      usb_case();
      report_and_stop();
   end

   // Watchdog far beyond the few hundred cycles the scenarios need.
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end
endmodule // tb

bind lhpm_top lhpm_monitor mon (.i_mclk(i_mclk), .i_reset(i_reset), .i_rd(i_rd), .i_addr(i_addr),
   .o_rd_data(o_rd_data), .i_host_we1_n(i_host_we1_n), .i_gpio_in(i_gpio_in),
   .o_usb_cable_detect(o_usb_cable_detect), .o_gpio_oe_n(o_gpio_oe_n), .o_lanes(o_lanes), .o_cfg(o_cfg));
